/* File: src/fspc_pkg.sv */
package fspc_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ---------------------------------------------------------------
	localparam logic [7:0] FSPC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] FSPC_OFS_KEY    = 8'h04;
	localparam logic [7:0] FSPC_OFS_PAGE   = 8'h08;
	localparam logic [7:0] FSPC_OFS_STATUS = 8'h0C;

	// ---------------------------------------------------------------
	// control field positions and reset values
	// ---------------------------------------------------------------
	localparam int FSPC_BIT_START = 15;
	localparam int FSPC_BIT_PROGRAM_ERASE_ENABLE  = 14;
	localparam int FSPC_BIT_ERR   = 13;
	localparam int FSPC_BIT_PGMO  = 12;
	localparam int FSPC_BIT_ERASE = 6;
	localparam logic [15:0] FSPC_CTRL_RST  = 16'h0000;
	localparam logic [15:0] FSPC_CTRL_WMSK = 16'h507F;
	localparam logic [7:0]  FSPC_PAGE_RST  = 8'h00;

	// ---------------------------------------------------------------
	// unlock keys, row geometry
	// ---------------------------------------------------------------
	localparam logic [7:0] FSPC_KEY1 = 8'h55;
	localparam logic [7:0] FSPC_KEY2 = 8'hAA;
	localparam int FSPC_ROW_WORDS = 32;
	localparam int FSPC_TBLWR_CYC = 2;

	// ---------------------------------------------------------------
	// operation codes
	// ---------------------------------------------------------------
	localparam logic [5:0] FSPC_OP_ER1 = 6'h18;
	localparam logic [5:0] FSPC_OP_ER2 = 6'h19;
	localparam logic [5:0] FSPC_OP_ER4 = 6'h1A;
	localparam logic [3:0] FSPC_OP_BOOT = 4'hA;
	localparam logic [3:0] FSPC_OP_ALL  = 4'h9;
	localparam logic [3:0] FSPC_OP_CFG  = 4'h5;
	localparam logic [3:0] FSPC_OP_EE   = 4'h4;
	localparam logic [3:0] FSPC_OP_GEN  = 4'h3;
	localparam logic [3:0] FSPC_OP_PROG = 4'h1;

	// ---------------------------------------------------------------
	// timing: self-timed operation length, in ns and cycles at 40 MHz
	// ---------------------------------------------------------------
	localparam int FSPC_CLK_MHZ   = 40;
	localparam int FSPC_T_OP_NS   = 2000;
	localparam int FSPC_OP_CYC    =
		(FSPC_T_OP_NS * FSPC_CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		FSPC_OP_NONE,
		FSPC_OP_ROWERASE,
		FSPC_OP_BULK,
		FSPC_OP_ROWPROG
	} fspc_kind_t;

	typedef enum {
		FSPC_IDLE,
		FSPC_BUSY
	} fspc_state_t;

endpackage : fspc_pkg

/* File: src/fspc_ctrl.sv */
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) table address is page over 16-bit EA
// (R2) low access reaches word bits 15..0
// (R3) high access reaches bits 23..16
// (R4) a row holds 32 instructions
// (R5) erase and write blocks aligned to size
// (R6) table writes only fill holding latches
// (R7) program works after any latch count
// (R8) latches load any order, last wins
// (R9) latch write takes two cycles
// (R10) software avoids reprogramming without erase
// (R11) software writes 55h then AAh to key
// (R12) processor stalled while operation runs
// (R13) start bit launches, hardware clears it
// (R14) enable bit permits or blocks operations
// (R15) error flag on bad sequence, else zero
// (R16) erase bit selects erase or program
// (R17) codes 011000/01/10 erase 1/2/4 rows
// (R18) boot and bulk erase serial mode only
// (R19) config, eeprom, general block erase codes
// (R20) code 0001xx programs one row
// (R21) undefined codes do nothing
// (R22) program-only bit matters only for eeprom
// (R23) software places two nops after start
// (R24) config space read only, writes refused
// (R25) start without keys or enable errors
module fspc_ctrl #(
	parameter int OP_CYC = fspc_pkg::FSPC_OP_CYC,
	parameter bit HAS_EE = 1'b1
) (
	input  wire logic        core_clk_i,    // system clock
	input  wire logic        rstn_i,        // sync reset, low
	input  wire logic        psel_i,        // apb select
	input  wire logic        penable_i,     // apb enable
	input  wire logic        pwrite_i,      // apb direction
	input  wire logic [7:0]  paddr_i,       // apb byte address
	input  wire logic [31:0] pwdata_i,      // apb write data
	output logic      [31:0] prdata_o,      // apb read data
	output logic             pready_o,      // apb ready
	output logic             pslverr_o,     // apb error
	input  wire logic        tbl_req_i,     // table access request
	input  wire logic        tbl_wr_i,      // 1 write, 0 read
	input  wire logic        tbl_high_i,    // high byte space
	input  wire logic        tbl_byte_i,    // byte mode
	input  wire logic [15:0] tbl_ea_i,      // effective address
	input  wire logic [15:0] tbl_wdata_i,   // write data
	output logic      [15:0] tbl_rdata_o,   // read data
	output logic             tbl_done_o,    // access done pulse
	output logic             tbl_refused_o, // write refused pulse
	output logic      [23:0] tbl_addr_o,    // formed address
	input  wire logic        serial_mode_i, // serial programming
	output logic             cpu_stall_o,   // processor stall
	output logic             op_go_o,       // operation launched
	output logic      [2:0]  op_kind_o,     // operation kind
	output logic      [5:0]  op_code_o,     // operation code
	output logic      [23:0] op_base_o,     // aligned base address
	output logic      [4:0]  op_rows_o      // rows affected
);
	import fspc_pkg::*;

	default clocking cb_chk @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	logic        acc;
	logic        wr_ctrl;
	logic        wr_key;
	logic        wr_page;
	logic [15:0] ctrl_q;
	logic [7:0]  page_q;
	logic [1:0]  key_q;
	logic        busy_q;
	logic        mapped;

	assign acc     = psel_i && penable_i;
	assign mapped  = paddr_i == FSPC_OFS_CTRL || paddr_i == FSPC_OFS_KEY
		|| paddr_i == FSPC_OFS_PAGE || paddr_i == FSPC_OFS_STATUS;
	assign wr_ctrl = acc && pwrite_i && paddr_i == FSPC_OFS_CTRL;
	assign wr_key  = acc && pwrite_i && paddr_i == FSPC_OFS_KEY;
	assign wr_page = acc && pwrite_i && paddr_i == FSPC_OFS_PAGE;
	assign pready_o  = 1'b1;
	assign pslverr_o = acc && !mapped;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				FSPC_OFS_CTRL:   prdata_o <= {16'h0000, ctrl_q};
				FSPC_OFS_PAGE:   prdata_o <= {24'h00_0000, page_q};
				FSPC_OFS_STATUS: prdata_o <= {30'h0, key_q == 2'd2, busy_q};
				default:         prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// unlock key tracker
	// ---------------------------------------------------------------
	// any other apb write breaks the pair, so the keys must be adjacent
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			key_q <= 2'd0;
		end else if (acc && pwrite_i) begin
			if (wr_key && pwdata_i[7:0] == FSPC_KEY1)
				key_q <= 2'd1; // R11
			else if (wr_key && key_q == 2'd1 && pwdata_i[7:0] == FSPC_KEY2)
				key_q <= 2'd2; // R11
			else
				key_q <= 2'd0;
		end
	end

	// ---------------------------------------------------------------
	// operation decode
	// ---------------------------------------------------------------
	logic        start_req;
	logic        start_ok;
	logic [5:0]  wcode;
	logic        werase;
	fspc_kind_t  kind;
	logic [4:0]  rows;

	assign start_req = wr_ctrl && pwdata_i[FSPC_BIT_START] && !busy_q;
	assign start_ok  = start_req && key_q == 2'd2
		&& pwdata_i[FSPC_BIT_PROGRAM_ERASE_ENABLE]; // R14 R25
	assign wcode  = pwdata_i[5:0];
	assign werase = pwdata_i[FSPC_BIT_ERASE];

	always_comb begin
		kind = FSPC_OP_NONE; // R21
		rows = 5'd0;
		if (werase) begin // R16
			if (wcode == FSPC_OP_ER1) begin
				kind = FSPC_OP_ROWERASE; // R17
				rows = 5'd1;
			end else if (wcode == FSPC_OP_ER2) begin
				kind = FSPC_OP_ROWERASE; // R17
				rows = 5'd2;
			end else if (wcode == FSPC_OP_ER4) begin
				kind = FSPC_OP_ROWERASE; // R17
				rows = 5'd4;
			end else if ((wcode[5:2] == FSPC_OP_BOOT
				|| wcode[5:2] == FSPC_OP_ALL) && serial_mode_i) begin
				kind = FSPC_OP_BULK; // R18
			end else if (wcode[5:2] == FSPC_OP_CFG
				|| wcode[5:2] == FSPC_OP_GEN) begin
				kind = FSPC_OP_BULK; // R19
			end else if (wcode[5:2] == FSPC_OP_EE && HAS_EE) begin
				kind = FSPC_OP_BULK; // R19 R22
			end
		end else if (wcode[5:2] == FSPC_OP_PROG) begin
			kind = FSPC_OP_ROWPROG; // R20 R7
			rows = 5'd1;
		end
	end

	// ---------------------------------------------------------------
	// control register and self-timed sequencer
	// ---------------------------------------------------------------
	fspc_state_t state_q;
	logic [$clog2(OP_CYC+1)-1:0] cnt_q;
	logic        op_done;

	assign op_done = state_q == FSPC_BUSY && cnt_q == '0;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state_q <= FSPC_IDLE;
			cnt_q   <= '0;
			busy_q  <= 1'b0;
		end else begin
			case (state_q)
				FSPC_IDLE: if (start_ok) begin
					state_q <= FSPC_BUSY;
					busy_q  <= 1'b1; // R12
					cnt_q   <= ($bits(cnt_q))'(OP_CYC - 1);
				end
				FSPC_BUSY: if (op_done) begin
					state_q <= FSPC_IDLE;
					busy_q  <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
				default: state_q <= FSPC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ctrl_q <= FSPC_CTRL_RST;
		end else begin
			if (wr_ctrl && !busy_q)
				ctrl_q[11:0] <= pwdata_i[11:0] & FSPC_CTRL_WMSK[11:0];
			if (wr_ctrl && !busy_q)
				ctrl_q[FSPC_BIT_PROGRAM_ERASE_ENABLE] <= pwdata_i[FSPC_BIT_PROGRAM_ERASE_ENABLE]; // R14
			if (wr_ctrl && !busy_q && HAS_EE)
				ctrl_q[FSPC_BIT_PGMO] <= pwdata_i[FSPC_BIT_PGMO]; // R22
			if (wr_ctrl && !busy_q && !pwdata_i[FSPC_BIT_ERR])
				ctrl_q[FSPC_BIT_ERR] <= 1'b0;
			if (start_req && !start_ok)
				ctrl_q[FSPC_BIT_ERR] <= 1'b1; // R15 R25
			else if (start_ok)
				ctrl_q[FSPC_BIT_ERR] <= 1'b0; // R15
			if (start_ok)
				ctrl_q[FSPC_BIT_START] <= 1'b1; // R13
			else if (op_done)
				ctrl_q[FSPC_BIT_START] <= 1'b0; // R13
		end
	end

	assign cpu_stall_o = busy_q; // R12

	// ---------------------------------------------------------------
	// launched operation: block-aligned base address
	// ---------------------------------------------------------------
	logic [23:0] row_idx;
	logic [23:0] base_row;

	assign row_idx = {page_q, tbl_ea_i} / 24'(2 * FSPC_ROW_WORDS); // R4
	always_comb begin
		base_row = row_idx;
		if (rows == 5'd2)
			base_row = {row_idx[23:1], 1'b0}; // R5
		else if (rows == 5'd4)
			base_row = {row_idx[23:2], 2'b00}; // R5
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			op_go_o   <= 1'b0;
			op_kind_o <= 3'd0;
			op_code_o <= 6'd0;
			op_base_o <= 24'h00_0000;
			op_rows_o <= 5'd0;
		end else begin
			op_go_o <= start_ok; // R6
			if (start_ok) begin
				op_kind_o <= kind;
				op_code_o <= wcode;
				op_base_o <= 24'(base_row * 24'(2 * FSPC_ROW_WORDS));
				op_rows_o <= rows;
			end
		end
	end

	// ---------------------------------------------------------------
	// table page and holding latches
	// ---------------------------------------------------------------
	logic [23:0] latch_q [FSPC_ROW_WORDS];
	logic [4:0]  widx;
	logic        tbl_cfg;
	logic        tbl_go;
	logic        tbl_wok;
	logic        ph_q;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			page_q <= FSPC_PAGE_RST;
		else if (wr_page && !busy_q)
			page_q <= pwdata_i[7:0];
	end

	assign tbl_addr_o = {page_q, tbl_ea_i}; // R1
	assign widx    = tbl_ea_i[5:1];
	assign tbl_cfg = page_q[7]; // R24
	assign tbl_go  = tbl_req_i && !busy_q && ph_q;
	assign tbl_wok = tbl_go && tbl_wr_i && !tbl_cfg; // R24

	// two-phase access: request held for two cycles per word
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			ph_q <= 1'b0;
		else if (tbl_req_i && !busy_q)
			ph_q <= !ph_q; // R9
		else
			ph_q <= 1'b0;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < FSPC_ROW_WORDS; i++)
				latch_q[i] <= 24'hFF_FFFF;
		end else if (tbl_wok) begin
			if (!tbl_high_i && !tbl_byte_i)
				latch_q[widx][15:0] <= tbl_wdata_i; // R2 R8
			else if (!tbl_high_i && tbl_ea_i[0])
				latch_q[widx][15:8] <= tbl_wdata_i[7:0]; // R2
			else if (!tbl_high_i)
				latch_q[widx][7:0] <= tbl_wdata_i[7:0]; // R2
			else if (!(tbl_byte_i && tbl_ea_i[0]))
				latch_q[widx][23:16] <= tbl_wdata_i[7:0]; // R3
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			tbl_rdata_o   <= 16'h0000;
			tbl_done_o    <= 1'b0;
			tbl_refused_o <= 1'b0;
		end else begin
			tbl_done_o    <= tbl_go; // R9
			tbl_refused_o <= tbl_go && tbl_wr_i && tbl_cfg; // R24
			if (tbl_go && !tbl_wr_i) begin
				if (tbl_high_i)
					tbl_rdata_o <= tbl_byte_i && tbl_ea_i[0] ? 16'h0000
						: {8'h00, latch_q[widx][23:16]}; // R3
				else if (tbl_byte_i)
					tbl_rdata_o <= {8'h00, tbl_ea_i[0]
						? latch_q[widx][15:8] : latch_q[widx][7:0]};
				else
					tbl_rdata_o <= latch_q[widx][15:0]; // R2
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_STALL_BUSY: assert property ( // R12
		op_go_o |-> cpu_stall_o) else $error("stall missing");
	AST_START_CLR: assert property ( // R13
		$fell(busy_q) |-> !ctrl_q[FSPC_BIT_START])
		else $error("start bit stuck");
	AST_NOKEY_ERR: assert property ( // R25
		start_req && key_q != 2'd2 |=> ctrl_q[FSPC_BIT_ERR] && !busy_q)
		else $error("no error on bad key");
	AST_PROGRAM_ERASE_ENABLE_BLOCK: assert property ( // R14
		start_req && !pwdata_i[FSPC_BIT_PROGRAM_ERASE_ENABLE] |=> !op_go_o)
		else $error("start while disabled");
	AST_OK_NOERR: assert property ( // R15
		start_ok |=> !ctrl_q[FSPC_BIT_ERR] && busy_q)
		else $error("error after good start");
	AST_BUSY_LEN: assert property ( // R12
		start_ok |=> busy_q [*2]) else $error("busy too short");
	AST_ADDR: assert property ( // R1
		tbl_addr_o[23:16] == page_q) else $error("bad table address");
	AST_CFG_RO: assert property ( // R24
		tbl_go && tbl_wr_i && tbl_cfg |=> tbl_refused_o)
		else $error("config write not refused");
	// a four-row block spans 256 program address units
	AST_ALIGN: assert property ( // R5
		op_go_o && op_rows_o == 5'd4 |-> op_base_o[7:0] == 8'h00)
		else $error("misaligned erase block");
	COV_ROWERASE: cover property (
		op_go_o && op_kind_o == FSPC_OP_ROWERASE);
	COV_ROWPROG: cover property (
		op_go_o && op_kind_o == FSPC_OP_ROWPROG);
	COV_BADSEQ: cover property (start_req && !start_ok);

endmodule : fspc_ctrl

/* File: dv/flash_self_program_control_tb_top.sv */
`timescale 1ns/1ps
module flash_self_program_control_tb_top;
	import fspc_pkg::*;
	localparam int OPC = 4;
	localparam int LIMIT = 20000;
	logic        core_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic        pready_o, pslverr_o;
	logic        tbl_req_i = 1'b0, tbl_wr_i = 1'b0;
	logic        tbl_high_i = 1'b0, tbl_byte_i = 1'b0;
	logic [15:0] tbl_ea_i = 16'h0, tbl_wdata_i = 16'h0, tbl_rdata_o;
	logic        tbl_done_o, tbl_refused_o, serial_mode_i = 1'b0;
	logic [23:0] tbl_addr_o, op_base_o;
	logic        cpu_stall_o, op_go_o;
	logic [2:0]  op_kind_o;
	logic [5:0]  op_code_o;
	logic [4:0]  op_rows_o;
	logic [7:0]  page_exp = 8'h00;
	int          n_mismatch = 0, compares = 0, cyc = 0;
	logic [31:0] r;
	logic        e, d, f;

	fspc_ctrl #(.OP_CYC(OPC), .HAS_EE(1'b1)) i_fspc_ctrl (
		.core_clk_i    (core_clk_i),
		.rstn_i        (rstn_i),
		.psel_i        (psel_i),
		.penable_i     (penable_i),
		.pwrite_i      (pwrite_i),
		.paddr_i       (paddr_i),
		.pwdata_i      (pwdata_i),
		.prdata_o      (prdata_o),
		.pready_o      (pready_o),
		.pslverr_o     (pslverr_o),
		.tbl_req_i     (tbl_req_i),
		.tbl_wr_i      (tbl_wr_i),
		.tbl_high_i    (tbl_high_i),
		.tbl_byte_i    (tbl_byte_i),
		.tbl_ea_i      (tbl_ea_i),
		.tbl_wdata_i   (tbl_wdata_i),
		.tbl_rdata_o   (tbl_rdata_o),
		.tbl_done_o    (tbl_done_o),
		.tbl_refused_o (tbl_refused_o),
		.tbl_addr_o    (tbl_addr_o),
		.serial_mode_i (serial_mode_i),
		.cpu_stall_o   (cpu_stall_o),
		.op_go_o       (op_go_o),
		.op_kind_o     (op_kind_o),
		.op_code_o     (op_code_o),
		.op_base_o     (op_base_o),
		.op_rows_o     (op_rows_o)
	);

	always #12.5 core_clk_i = ~core_clk_i;

	// ---------------------------------------------------------------
	// checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	// hang guard, far above the expected run length
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ---------------------------------------------------------------
	// bus drivers
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd,
			output logic err);
		@(posedge core_clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		// no wait count assumed; the hang guard ends a stuck bus
		do begin
			@(posedge core_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic tbl(input logic w, hi, by, input logic [15:0] ea,
			input logic [15:0] wd, output logic [15:0] rd,
			output logic dn, output logic rf);
		@(posedge core_clk_i);
		tbl_req_i   <= 1'b1;
		tbl_wr_i    <= w;
		tbl_high_i  <= hi;
		tbl_byte_i  <= by;
		tbl_ea_i    <= ea;
		tbl_wdata_i <= wd;
		@(posedge core_clk_i);
		chk("tbl_addr", {8'h0, tbl_addr_o}, {8'h0, page_exp, ea});
		@(posedge core_clk_i);
		chk("done early", {31'h0, tbl_done_o}, 32'h0);
		tbl_req_i <= 1'b0;
		@(posedge core_clk_i);
		rd = tbl_rdata_o;
		dn = tbl_done_o;
		rf = tbl_refused_o;
	endtask : tbl

	task automatic unlock();
		apb(1'b1, FSPC_OFS_KEY, {24'h0, FSPC_KEY1}, r, e);
		apb(1'b1, FSPC_OFS_KEY, {24'h0, FSPC_KEY2}, r, e);
	endtask : unlock

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, FSPC_OFS_CTRL, 32'h0, r, e);
		chk("ctrl reset", r, 32'h0);
		apb(1'b0, FSPC_OFS_PAGE, 32'h0, r, e);
		chk("page reset", r, 32'h0);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		apb(1'b1, FSPC_OFS_CTRL, 32'h0000_3FFF, r, e);
		apb(1'b0, FSPC_OFS_CTRL, 32'h0, r, e);
		chk("ctrl mask", r, 32'h0000_107F);
		apb(1'b0, FSPC_OFS_KEY, 32'h0, r, e);
		chk("key reads 0", r, 32'h0);
	endtask : t_regs

	task automatic t_latch();
		logic [15:0] rd;
		page_exp = 8'h01;
		apb(1'b1, FSPC_OFS_PAGE, 32'h1, r, e);
		tbl(1'b0, 1'b1, 1'b0, 16'h0008, 16'h0, rd, d, f);
		chk("untouched high", {16'h0, rd}, 32'h00FF);
		tbl(1'b1, 1'b0, 1'b0, 16'h0006, 16'h1234, rd, d, f);
		chk("wr done", {31'h0, d}, 32'h1);
		tbl(1'b1, 1'b1, 1'b0, 16'h0006, 16'h005A, rd, d, f);
		tbl(1'b1, 1'b0, 1'b0, 16'h0006, 16'hABCD, rd, d, f);
		tbl(1'b0, 1'b0, 1'b0, 16'h0006, 16'h0, rd, d, f);
		chk("low rewrite", {16'h0, rd}, 32'hABCD);
		tbl(1'b0, 1'b1, 1'b0, 16'h0006, 16'h0, rd, d, f);
		chk("high word", {16'h0, rd}, 32'h005A);
		tbl(1'b0, 1'b0, 1'b1, 16'h0007, 16'h0, rd, d, f);
		chk("byte upper", {24'h0, rd[7:0]}, 32'hAB);
		page_exp = 8'h80;
		apb(1'b1, FSPC_OFS_PAGE, 32'h80, r, e);
		tbl(1'b1, 1'b0, 1'b0, 16'h0006, 16'h1111, rd, d, f);
		chk("cfg refused", {31'h0, f}, 32'h1);
		page_exp = 8'h01;
		apb(1'b1, FSPC_OFS_PAGE, 32'h1, r, e);
	endtask : t_latch

	task automatic t_op(input logic [7:0] lo, input logic [2:0] k,
			input logic [4:0] rows, input logic [23:0] base);
		logic [15:0] rd;
		int ng, ns;
		ng = 0;
		ns = 0;
		tbl(1'b1, 1'b0, 1'b0, 16'h12F4, 16'h0, rd, d, f);
		unlock();
		apb(1'b0, FSPC_OFS_STATUS, 32'h0, r, e);
		chk("unlocked", r, 32'h2);
		apb(1'b1, FSPC_OFS_CTRL, {16'h0, 8'hC0, lo}, r, e);
		repeat (2 * OPC + 8) begin
			@(posedge core_clk_i);
			if (op_go_o === 1'b1) begin
				ng++;
				chk("kind", {29'h0, op_kind_o}, {29'h0, k});
				chk("code", {26'h0, op_code_o}, {26'h0, lo[5:0]});
				if (k == 3'd1 || k == 3'd3) begin
					chk("rows", {27'h0, op_rows_o}, {27'h0, rows});
					chk("base", {8'h0, op_base_o}, {8'h0, base});
				end
			end
			if (cpu_stall_o === 1'b1)
				ns++;
		end
		chk("go count", ng, 1);
		chk("stall length", ns, OPC);
		apb(1'b0, FSPC_OFS_CTRL, 32'h0, r, e);
		chk("ctrl after op", r, {16'h0, 8'h40, lo});
	endtask : t_op

	task automatic t_bad(input logic [31:0] k1, k2, cw);
		int ng;
		ng = 0;
		apb(1'b1, FSPC_OFS_CTRL, 32'h0, r, e);
		apb(1'b1, FSPC_OFS_KEY, k1, r, e);
		apb(1'b1, FSPC_OFS_KEY, k2, r, e);
		apb(1'b1, FSPC_OFS_CTRL, cw, r, e);
		repeat (2 * OPC + 4) begin
			@(posedge core_clk_i);
			if (op_go_o === 1'b1 || cpu_stall_o === 1'b1)
				ng++;
		end
		chk("no launch", ng, 0);
		apb(1'b0, FSPC_OFS_CTRL, 32'h0, r, e);
		chk("err flag", {31'h0, r[13]}, 32'h1);
		chk("start clear", {31'h0, r[15]}, 32'h0);
	endtask : t_bad

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_latch();
		t_op(8'h58, 3'd1, 5'd1, 24'h0112C0);
		t_op(8'h59, 3'd1, 5'd2, 24'h011280);
		t_op(8'h5A, 3'd1, 5'd4, 24'h011200);
		t_op(8'h04, 3'd3, 5'd1, 24'h0112C0);
		t_op(8'h4C, 3'd2, 5'd0, 24'h0);
		t_op(8'h54, 3'd2, 5'd0, 24'h0);
		t_op(8'h50, 3'd2, 5'd0, 24'h0);
		t_op(8'h7F, 3'd0, 5'd0, 24'h0);
		t_op(8'h00, 3'd0, 5'd0, 24'h0);
		t_op(8'h64, 3'd0, 5'd0, 24'h0);
		serial_mode_i <= 1'b1;
		t_op(8'h64, 3'd2, 5'd0, 24'h0);
		t_op(8'h68, 3'd2, 5'd0, 24'h0);
		serial_mode_i <= 1'b0;
		t_bad(32'h00, 32'h00, 32'h0000_C058);
		t_bad(32'hAA, 32'h55, 32'h0000_C058);
		t_bad(32'h55, 32'hAA, 32'h0000_8058);
		apb(1'b1, FSPC_OFS_CTRL, 32'h0, r, e);
		apb(1'b0, FSPC_OFS_CTRL, 32'h0, r, e);
		chk("err cleared", r, 32'h0);
		give_verdict();
	end
endmodule : flash_self_program_control_tb_top
